// ==== hdl/ptc_defines.vh ====
// Register map, field positions and encodings of the periodic timer
`ifndef PTC_DEFINES_VH
`define PTC_DEFINES_VH

// Byte addresses on the AXI4-Lite bus, one aligned word each
`define PTC_A_CTRL0      6'h00
`define PTC_A_CTRL1      6'h04
`define PTC_A_CTRL2      6'h08
`define PTC_A_CNT_LO     6'h0c
`define PTC_A_CNT_HI     6'h10
`define PTC_A_CMPA_LO    6'h14
`define PTC_A_CMPA_HI    6'h18
`define PTC_A_CMPB_LO    6'h1c
`define PTC_A_CMPB_HI    6'h20
`define PTC_A_PER_LO     6'h24
`define PTC_A_PER_HI     6'h28

// Clock and on/off register fields
`define PTC_F_HOLD       7
`define PTC_F_CKSEL_HI   6
`define PTC_F_CKSEL_LO   4
`define PTC_F_ON         3

// Mode and output register fields
`define PTC_F_MODE_HI    7
`define PTC_F_MODE_LO    6
`define PTC_F_PIN_HI     5
`define PTC_F_PIN_LO     4
`define PTC_F_OC         3
`define PTC_F_POL        2
`define PTC_F_CAPTS      1
`define PTC_F_CCLR       0

// Capture clear register fields
`define PTC_F_TCLR_HI    2
`define PTC_F_TCLR_LO    1

// Operating modes
`define PTC_M_CMP        2'h0
`define PTC_M_CAP        2'h1
`define PTC_M_PWM        2'h2
`define PTC_M_TMR        2'h3

// Count clock sources
`define PTC_CK_SYS4      3'h0
`define PTC_CK_SYS       3'h1
`define PTC_CK_H16       3'h2
`define PTC_CK_H64       3'h3
`define PTC_CK_SUB0      3'h4
`define PTC_CK_SUB1      3'h5
`define PTC_CK_EXTR      3'h6
`define PTC_CK_EXTF      3'h7

// Two-bit pin function and edge codes
`define PTC_P_00         2'h0
`define PTC_P_01         2'h1
`define PTC_P_10         2'h2
`define PTC_P_11         2'h3

// Prescaler terminal counts
`define PTC_DIV4_END     6'h03
`define PTC_DIV16_END    6'h0f
`define PTC_DIV64_END    6'h3f

// AXI responses
`define PTC_RESP_OKAY    2'h0
`define PTC_RESP_SLVERR  2'h2

`endif

// ==== hdl/ptc_timer.v ====
// Periodic timer: control registers, counter, capture and waveform output
`timescale 1ns/1ns
`include "ptc_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Count-hold bit freezes the counter, module stays on, resumes from held value; capture-mode edge clears still zero it.
// - Clock select picks sys/4, sys, high/16, high/64, sub, or ext pin edges.
// - On-bit rising clears counter; falling stops it and keeps residual value.
// - On-bit rising returns wave output to initial level in output modes.
// - Mode field: compare, capture, PWM/single pulse, timer/counter.
// - Compare mode A match: no change, drive low, drive high, toggle.
// - PWM mode pin function: inactive, active, PWM waveform, single pulse.
// - Capture with clear select 00 latches into compare A on chosen edge.
// - Capture with clear select nonzero routes rising to B, falling to A.
// - Capture source bit picks capture pin at 0, ext clock pin at 1.
// - Level bit sets initial level or PWM active level; ignored in timer mode.
// - Single pulse mode: level bit sets output at on-bit rising.
// - Invert bit inverts wave output, no effect in timer mode.
// - Clear source 1 clears on A match; 0 on P match or overflow.
// - Clear source bit ignored in PWM, single pulse and capture modes.
// - In capture mode, clear select adds edges of the selected capture source to P match clear.
// - Latch edge flag reads 1 for rising, 0 for falling latch edge.
// - Counter readable only via low/high bytes; unused high bits read zero.
// - Compare A low byte is read/write and resets to zero.
// - Low byte writes go to a buffer moved in on high byte write.
// - High byte reads copy the low byte into the buffer for next low read.
// - Inverted output always carries the inverse of the wave output.
module ptc_timer #(
  parameter WIDE = 1
)(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Internal clock enables from the clock unit
  input  wire        high_clock_en,
  input  wire        sub_clock_en,
  // AXI4-Lite write address
  input  wire [5:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [5:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Pins
  input  wire        ext_clock_pin,
  input  wire        capture_pin,
  output reg         wave_out_pin,
  output reg         wave_out_inv_pin
);

localparam CW = WIDE ? 16 : 10;

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [7:0]    ctrl_clock_and_onoff;
reg  [7:0]    ctrl_mode_and_output;
reg  [1:0]    capture_clear_select;
reg           latch_edge_flag;
reg  [CW-1:0] count;
reg  [CW-1:0] compare_a_value;
reg  [CW-1:0] compare_b_value;
reg  [CW-1:0] period_value;
reg  [7:0]    byte_buffer;
reg           wave;
reg           pulse_armed;
reg           on_d;
reg  [5:0]    prescale;

wire          count_hold_bit       = ctrl_clock_and_onoff[`PTC_F_HOLD];
wire [2:0]    count_clock_select   = ctrl_clock_and_onoff[`PTC_F_CKSEL_HI:`PTC_F_CKSEL_LO];
wire          module_on_bit        = ctrl_clock_and_onoff[`PTC_F_ON];
wire [1:0]    operating_mode_field = ctrl_mode_and_output[`PTC_F_MODE_HI:`PTC_F_MODE_LO];
wire [1:0]    pin_function_field   = ctrl_mode_and_output[`PTC_F_PIN_HI:`PTC_F_PIN_LO];
wire          output_level_control = ctrl_mode_and_output[`PTC_F_OC];
wire          output_invert_bit    = ctrl_mode_and_output[`PTC_F_POL];
wire          capture_source_bit   = ctrl_mode_and_output[`PTC_F_CAPTS];
wire          clear_source_bit     = ctrl_mode_and_output[`PTC_F_CCLR];

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detect

reg  [1:0] ck_sync;
reg  [1:0] cp_sync;
reg        ck_last;
reg        cp_last;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    ck_sync <= 2'h0;
    cp_sync <= 2'h0;
    ck_last <= 1'b0;
    cp_last <= 1'b0;
  end
  else
  begin
    ck_sync <= {ck_sync[0], ext_clock_pin};
    cp_sync <= {cp_sync[0], capture_pin};
    ck_last <= ck_sync[1];
    cp_last <= cp_sync[1];
  end
end

wire ck_rise = ck_sync[1] & ~ck_last;
wire ck_fall = ~ck_sync[1] & ck_last;
wire src_lvl  = capture_source_bit ? ck_sync[1] : cp_sync[1];
wire src_last = capture_source_bit ? ck_last : cp_last;
wire cap_rise = src_lvl & ~src_last;
wire cap_fall = ~src_lvl & src_last;

////////////////////////////////////////////////////////////////////////////////
// Count clock selection

reg tick_src;

always @(posedge aclk)
begin
  if (!aresetn)
    prescale <= 6'h00;
  else if (count_clock_select == `PTC_CK_SYS4 || high_clock_en)
    prescale <= prescale + 6'h01;
end

always @*
begin
  case (count_clock_select)
    `PTC_CK_SYS4: tick_src = (prescale[1:0] == `PTC_DIV4_END);
    `PTC_CK_SYS:  tick_src = 1'b1;
    `PTC_CK_H16:  tick_src = high_clock_en & (prescale[3:0] == `PTC_DIV16_END);
    `PTC_CK_H64:  tick_src = high_clock_en & (prescale == `PTC_DIV64_END);
    `PTC_CK_SUB0,
    `PTC_CK_SUB1: tick_src = sub_clock_en;
    `PTC_CK_EXTR: tick_src = ck_rise;
    `PTC_CK_EXTF: tick_src = ck_fall;
    default:      tick_src = 1'b0;
  endcase
end

wire tick = tick_src & module_on_bit & ~count_hold_bit;

////////////////////////////////////////////////////////////////////////////////
// Counter, comparators, capture

wire on_rise   = module_on_bit & ~on_d;
wire cap_mode  = (operating_mode_field == `PTC_M_CAP);
wire pwm_mode  = (operating_mode_field == `PTC_M_PWM);
wire cmp_mode  = (operating_mode_field == `PTC_M_CMP);
wire match_a   = tick & (count + 1'b1 == compare_a_value);
wire match_p   = tick & (count + 1'b1 == period_value);
wire overflow  = tick & (&count);
wire tclr_none = (capture_clear_select == `PTC_P_00);
wire cap_on    = cap_mode & module_on_bit;

// Capture routing by edge and clear select
wire cap_a = cap_on & (tclr_none ?
               ((pin_function_field == `PTC_P_00) & cap_rise) |
               ((pin_function_field == `PTC_P_01) & cap_fall) |
               ((pin_function_field == `PTC_P_10) & (cap_rise | cap_fall)) :
               ((pin_function_field == `PTC_P_01) & cap_fall) |
               ((pin_function_field == `PTC_P_10) & cap_fall));
wire cap_b = cap_on & ~tclr_none &
             (pin_function_field == `PTC_P_00 || pin_function_field == `PTC_P_10) &
             cap_rise;

// Edge clear in capture mode
wire edge_clr = cap_on & (
                  (capture_clear_select == `PTC_P_01 & cap_rise) |
                  (capture_clear_select == `PTC_P_10 & cap_fall) |
                  (capture_clear_select == `PTC_P_11 & (cap_rise | cap_fall)));

// Clear source only counts in compare and timer modes
wire use_cclr = ~(pwm_mode | cap_mode) & clear_source_bit;
wire clr_p    = (period_value == {CW{1'b0}}) ? overflow : match_p;
wire clr      = use_cclr ? match_a : clr_p;

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    count           <= {CW{1'b0}};
    on_d            <= 1'b0;
    latch_edge_flag <= 1'b0;
  end
  else
  begin
    on_d <= module_on_bit;
    if (on_rise)
      count <= {CW{1'b0}};
    else if (edge_clr || clr)
      count <= {CW{1'b0}};
    else if (tick)
      count <= count + 1'b1;
    if (cap_a | cap_b)
      latch_edge_flag <= cap_rise;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Waveform output

wire at_duty = (count >= compare_a_value);

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    wave        <= 1'b0;
    pulse_armed <= 1'b0;
  end
  else if (on_rise)
  begin
    wave        <= cmp_mode & output_level_control;
    pulse_armed <= 1'b1;
  end
  else if (cmp_mode && match_a)
  begin
    case (pin_function_field)
      `PTC_P_01: wave <= 1'b0;
      `PTC_P_10: wave <= 1'b1;
      `PTC_P_11: wave <= ~wave;
      default:   wave <= wave;
    endcase
  end
  else if (pwm_mode)
  begin
    case (pin_function_field)
      `PTC_P_00: wave <= 1'b0;
      `PTC_P_01: wave <= 1'b1;
      `PTC_P_10: wave <= ~at_duty;
      default:
      begin
        if (pulse_armed && match_a)
        begin
          wave        <= 1'b0;
          pulse_armed <= 1'b0;
        end
        else if (pulse_armed)
          wave <= module_on_bit;
      end
    endcase
  end
end

// Output-level and invert handling; timer mode holds wave_out_pin low and wave_out_inv_pin high
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    wave_out_pin     <= 1'b0;
    wave_out_inv_pin <= 1'b1;
  end
  else if (operating_mode_field == `PTC_M_TMR)
  begin
    wave_out_pin     <= 1'b0;
    wave_out_inv_pin <= 1'b1;
  end
  else
  begin
    wave_out_pin     <= (pwm_mode ? (wave ~^ output_level_control) : wave)
                        ^ output_invert_bit;
    wave_out_inv_pin <= ~((pwm_mode ? (wave ~^ output_level_control) : wave)
                        ^ output_invert_bit);
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

reg        aw_held;
reg        w_held;
reg [5:0]  aw_addr;
reg [7:0]  w_byte;
reg        w_lane0;

assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire       wr_go   = aw_held & w_held;
wire       rd_go   = s_axi_arvalid & s_axi_arready;
wire [7:0] hi_mask = WIDE ? 8'hff : 8'h03;

function [7:0] hi_of;
  input [CW-1:0] v;
  reg   [15:0]   w;
  begin
    w     = 16'h0000;
    w     = w | v;
    hi_of = w[15:8];
  end
endfunction

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_held              <= 1'b0;
    w_held               <= 1'b0;
    aw_addr              <= 6'h00;
    w_byte               <= 8'h00;
    w_lane0              <= 1'b0;
    s_axi_bvalid         <= 1'b0;
    s_axi_bresp          <= `PTC_RESP_OKAY;
    ctrl_clock_and_onoff <= 8'h00;
    ctrl_mode_and_output <= 8'h00;
    capture_clear_select <= 2'h0;
    compare_a_value      <= {CW{1'b0}};
    compare_b_value      <= {CW{1'b0}};
    period_value         <= {CW{1'b0}};
    byte_buffer          <= 8'h00;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
    // Capture wins over a same-cycle software write of the value
    if (wr_go)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= `PTC_RESP_OKAY;
      if (w_lane0)
        case (aw_addr)
          `PTC_A_CTRL0:   ctrl_clock_and_onoff <= {w_byte[7:3], 3'h0};
          `PTC_A_CTRL1:   ctrl_mode_and_output <= w_byte;
          `PTC_A_CTRL2:   capture_clear_select <= w_byte[`PTC_F_TCLR_HI:`PTC_F_TCLR_LO];
          `PTC_A_CMPA_LO,
          `PTC_A_CMPB_LO,
          `PTC_A_PER_LO:  byte_buffer <= w_byte;
          `PTC_A_CMPA_HI: compare_a_value <= {w_byte & hi_mask, byte_buffer};
          `PTC_A_CMPB_HI: compare_b_value <= {w_byte & hi_mask, byte_buffer};
          `PTC_A_PER_HI:  period_value <= {w_byte & hi_mask, byte_buffer};
          `PTC_A_CNT_LO,
          `PTC_A_CNT_HI:  s_axi_bresp <= `PTC_RESP_OKAY;
          default:        s_axi_bresp <= `PTC_RESP_SLVERR;
        endcase
      else if (aw_addr > `PTC_A_PER_HI || aw_addr[1:0] != 2'h0)
        s_axi_bresp <= `PTC_RESP_SLVERR;
    end
    if (cap_a)
      compare_a_value <= count;
    if (cap_b)
      compare_b_value <= count;
    // High byte read snapshots the low byte
    if (rd_go)
      case (s_axi_araddr)
        `PTC_A_CNT_HI:  byte_buffer <= count[7:0];
        `PTC_A_CMPA_HI: byte_buffer <= compare_a_value[7:0];
        `PTC_A_CMPB_HI: byte_buffer <= compare_b_value[7:0];
        `PTC_A_PER_HI:  byte_buffer <= period_value[7:0];
        default:        byte_buffer <= byte_buffer;
      endcase
  end
end

always @(posedge aclk)
begin
  if (!aresetn)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata  <= 32'h00000000;
    s_axi_rresp  <= `PTC_RESP_OKAY;
  end
  else if (rd_go)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp  <= `PTC_RESP_OKAY;
    case (s_axi_araddr)
      `PTC_A_CTRL0:   s_axi_rdata <= {24'h000000, ctrl_clock_and_onoff};
      `PTC_A_CTRL1:   s_axi_rdata <= {24'h000000, ctrl_mode_and_output};
      `PTC_A_CTRL2:   s_axi_rdata <= {29'h00000000, capture_clear_select, latch_edge_flag};
      `PTC_A_CNT_LO,
      `PTC_A_CMPA_LO,
      `PTC_A_CMPB_LO,
      `PTC_A_PER_LO:  s_axi_rdata <= {24'h000000, byte_buffer};
      `PTC_A_CNT_HI:  s_axi_rdata <= {24'h000000, hi_of(count)};
      `PTC_A_CMPA_HI: s_axi_rdata <= {24'h000000, hi_of(compare_a_value)};
      `PTC_A_CMPB_HI: s_axi_rdata <= {24'h000000, hi_of(compare_b_value)};
      `PTC_A_PER_HI:  s_axi_rdata <= {24'h000000, hi_of(period_value)};
      default:
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PTC_RESP_SLVERR;
      end
    endcase
  end
  else if (s_axi_rvalid && s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

endmodule

// ==== testbench/ptc_pins_model.sv ====
// Far-side pin model: external count clock and capture input
`timescale 1ns/1ns
module ptc_pins_model (
  // Clock
  input  wire aclk,
  // Pins driven towards the timer
  output reg  ext_clock_pin,
  output reg  capture_pin
);
  initial
  begin
    ext_clock_pin = 1'b0;
    capture_pin   = 1'b0;
  end
  //////////////////////////////////////////
  // Each level stands at least 4 cycles so the two-flop synchroniser sees it
  task pulse(input integer n);
    begin
      repeat (n)
      begin
        @(posedge aclk);
        ext_clock_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        ext_clock_pin <= 1'b0;
        repeat (4) @(posedge aclk);
      end
    end
  endtask
  // Pin stands still between frames
  task cap(input v);
    begin
      @(posedge aclk);
      capture_pin <= v;
      repeat (6) @(posedge aclk);
    end
  endtask
endmodule

// ==== testbench/ptc_timer_chk.sv ====
// Concurrent checks on the timer's bus handshakes and output pins
`timescale 1ns/1ns
module ptc_timer_chk (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Pins
  input wire        wave_out_pin,
  input wire        wave_out_inv_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence s_wr_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_inv; wave_out_inv_pin == !wave_out_pin; endproperty
  property p_rd; s_rd_taken |=> s_axi_rvalid; endproperty
  property p_rhold; s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rzero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  property p_arr; s_axi_arready == !s_axi_rvalid; endproperty
  property p_bhold; s_wr_wait |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_bend; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_rst; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !wave_out_pin; endproperty
  a_inv: assert property (p_inv) else $error("inverted pin not complement");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_rzero: assert property (p_rzero) else $error("upper read bits set");
  a_arr: assert property (p_arr) else $error("arready wrong");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_block: assert property (p_block) else $error("write taken during response");
  a_bend: assert property (p_bend) else $error("write response stuck");
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind ptc_timer ptc_timer_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wave_out_pin, .wave_out_inv_pin);

// ==== testbench/testbench.sv ====
// Self-checking bench for the periodic timer
`timescale 1ns/1ns
`include "ptc_defines.vh"
module testbench;
  reg         aclk;
  reg         aresetn;
  reg  [5:0]  s_axi_awaddr;
  reg         s_axi_awvalid;
  reg  [31:0] s_axi_wdata;
  reg         s_axi_wvalid;
  reg         s_axi_bready;
  reg         sub_clock_en;
  reg  [3:0]  s_axi_wstrb;
  reg  [5:0]  s_axi_araddr;
  reg         s_axi_arvalid;
  reg         s_axi_rready;
  wire        s_axi_awready;
  wire        s_axi_wready;
  wire [1:0]  s_axi_bresp;
  wire        s_axi_bvalid;
  wire        s_axi_arready;
  wire [31:0] s_axi_rdata;
  wire [1:0]  s_axi_rresp;
  wire        s_axi_rvalid;
  wire        ext_clock_pin;
  wire        capture_pin;
  wire        wave_out_pin;
  wire        wave_out_inv_pin;
  integer     errors;
  integer     cmp_count;
  integer     i;
  reg  [31:0] rdat;
  reg  [1:0]  rrsp;
  reg  [15:0] v1;
  reg  [15:0] v2;
  // Mode/output settings and {initial, after match} levels per case
  localparam [71:0] c1_tab  = 72'h08_18_20_30_25_88_98_a9_b8;
  localparam [17:0] exp_tab = 18'b11_10_01_01_10_00_11_10_10;

  ptc_timer dut (.aclk, .aresetn, .high_clock_en(1'b1), .sub_clock_en,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_clock_pin, .capture_pin, .wave_out_pin, .wave_out_inv_pin);
  ptc_pins_model pins (.aclk, .ext_clock_pin, .capture_pin);

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  //////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [5:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rdchk(input [5:0] a, input [31:0] exp);
    begin
      rd(a);
      chk(rdat, exp);
    end
  endtask
  // High byte first so the low byte comes from the snapshot buffer
  task rcnt(output [15:0] v);
    begin
      rd(`PTC_A_CNT_HI);
      v[15:8] = rdat[7:0];
      rd(`PTC_A_CNT_LO);
      v[7:0] = rdat[7:0];
    end
  endtask
  //////////////////////////////////////////
  task t_regs;
    begin
      rdchk(`PTC_A_CTRL0, 0);
      rdchk(`PTC_A_CTRL1, 0);
      rdchk(`PTC_A_CTRL2, 0);
      rdchk(`PTC_A_CMPA_LO, 0);
      // Lane 0 disabled: the write must leave the register alone
      s_axi_wstrb <= 4'h0;
      wr(`PTC_A_CTRL1, 8'hff);
      s_axi_wstrb <= 4'hf;
      rdchk(`PTC_A_CTRL1, 0);
      wr(`PTC_A_CTRL0, 8'hff);
      rdchk(`PTC_A_CTRL0, 32'hf8);
      wr(`PTC_A_CTRL2, 8'hff);
      rdchk(`PTC_A_CTRL2, 32'h06);
      wr(`PTC_A_CNT_LO, 8'haa);
      wr(`PTC_A_CNT_HI, 8'h55);
      rcnt(v1);
      chk(v1, 0);
      rd(6'h2c);
      chk(rrsp, `PTC_RESP_SLVERR);
      wr(`PTC_A_CTRL0, 8'h00);
      wr(`PTC_A_CTRL2, 8'h00);
    end
  endtask
  task t_buf;
    begin
      wr(`PTC_A_CMPA_LO, 8'h34);
      wr(`PTC_A_CMPA_HI, 8'h12);
      wr(`PTC_A_CMPA_LO, 8'h56);
      rdchk(`PTC_A_CMPA_HI, 32'h12);
      rdchk(`PTC_A_CMPA_LO, 32'h34);
      wr(`PTC_A_CMPA_LO, 8'h05);
      wr(`PTC_A_CMPA_HI, 8'h00);
    end
  endtask
  task t_hold;
    begin
      wr(`PTC_A_CTRL0, 8'h98);
      rcnt(v1);
      chk(v1, 0);
      wr(`PTC_A_CTRL0, 8'h18);
      wr(`PTC_A_CTRL0, 8'h98);
      rcnt(v1);
      repeat (20) @(posedge aclk);
      rcnt(v2);
      chk(v2, v1);
      chk(v1 != 0, 1);
      wr(`PTC_A_CTRL0, 8'h18);
      wr(`PTC_A_CTRL0, 8'h10);
      rcnt(v1);
      repeat (20) @(posedge aclk);
      rcnt(v2);
      chk(v2, v1);
    end
  endtask
  task t_ext;
    begin
      for (i = 6; i < 8; i = i + 1)
      begin
        wr(`PTC_A_CTRL0, 8'h00);
        wr(`PTC_A_CTRL0, {1'b0, i[2:0], 4'h8});
        pins.pulse(5);
        rcnt(v1);
        chk(v1, 5);
      end
    end
  endtask
  task t_cmp;
    begin
      for (i = 0; i < 9; i = i + 1)
      begin
        wr(`PTC_A_CTRL0, 8'h00);
        wr(`PTC_A_CTRL1, c1_tab[71-8*i -: 8]);
        wr(`PTC_A_CTRL0, 8'h68);
        repeat (3) @(posedge aclk);
        chk(wave_out_pin, exp_tab[17-2*i]);
        pins.pulse(4);
        chk(wave_out_pin, exp_tab[17-2*i]);
        pins.pulse(1);
        chk(wave_out_pin, exp_tab[16-2*i]);
        rcnt(v1);
        if (i < 8)
          chk(v1, (i == 4) ? 0 : 5);
      end
    end
  endtask
  task t_cap;
    begin
      wr(`PTC_A_CTRL0, 8'h00);
      wr(`PTC_A_CTRL1, 8'h40);
      wr(`PTC_A_CTRL0, 8'h68);
      pins.pulse(3);
      pins.cap(1'b1);
      rdchk(`PTC_A_CMPA_HI, 0);
      rdchk(`PTC_A_CMPA_LO, 3);
      pins.cap(1'b0);
      wr(`PTC_A_CTRL0, 8'h00);
      wr(`PTC_A_CTRL2, 8'h02);
      wr(`PTC_A_CTRL1, 8'h60);
      wr(`PTC_A_CTRL0, 8'h68);
      pins.pulse(3);
      pins.cap(1'b1);
      rdchk(`PTC_A_CTRL2, 32'h03);
      pins.pulse(2);
      pins.cap(1'b0);
      rdchk(`PTC_A_CTRL2, 32'h02);
      rdchk(`PTC_A_CMPB_HI, 0);
      rdchk(`PTC_A_CMPB_LO, 3);
      rdchk(`PTC_A_CMPA_HI, 0);
      rdchk(`PTC_A_CMPA_LO, 2);
    end
  endtask
  task t_tmr;
    begin
      wr(`PTC_A_CTRL0, 8'h00);
      wr(`PTC_A_CTRL1, 8'hcc);
      wr(`PTC_A_CTRL0, 8'h68);
      repeat (3) @(posedge aclk);
      chk(wave_out_pin, 0);
    end
  endtask
  task print_verdict;
    begin
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  //////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge aclk);
    errors = errors + 1;
    print_verdict;
  end
  initial
  begin
    errors        = 0;
    cmp_count     = 0;
    aresetn       = 1'b0;
    s_axi_awaddr  = 6'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h00000000;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    sub_clock_en  = 1'b0;
    s_axi_wstrb   = 4'hf;
    s_axi_araddr  = 6'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_buf;
    t_hold;
    t_ext;
    t_cmp;
    t_cap;
    t_tmr;
    print_verdict;
  end
endmodule
